// >>> verilog/tpcd_pkg.sv
// Constants shared by the tone processor command decoder.
package tpcd_pkg;

  // ****************************************
  // Command bytes
  // ****************************************
  localparam logic [7:0] CMD_RESET = 8'h01;
  localparam logic [7:0] CMD_CTRL  = 8'h30;
  localparam logic [7:0] CMD_STAT  = 8'h31;
  localparam logic [7:0] CMD_FREQ  = 8'h32;
  localparam logic [7:0] CMD_LOSS  = 8'h33;
  localparam logic [7:0] CMD_TONE1 = 8'h34;
  localparam logic [7:0] CMD_TONE2 = 8'h35;
  localparam logic [7:0] CMD_TIMER = 8'h36;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_AUDIO   = 7;
  localparam int CTL_TX_IE   = 6;
  localparam int CTL_DEC_IE  = 5;
  localparam int CTL_SUM     = 4;
  localparam int CTL_BAND_HI = 3;
  localparam int CTL_BAND_LO = 2;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int ST_MEAS  = 0;
  localparam int ST_LOSS  = 1;
  localparam int ST_TIMER = 2;
  localparam int ST_LOGIC = 3;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  PERIOD_RST = 8'h00;
  localparam logic [15:0] TONE_RST   = 16'h0000;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam logic [4:0]  STAT_BITS  = 5'h07;
  localparam logic [4:0]  FREQ_BITS  = 5'h0f;

  typedef enum logic [1:0] {
    TPCD_CMD,
    TPCD_BYTE1,
    TPCD_BYTE2,
    TPCD_SKIP
  } tpcd_phase_t;

endpackage

// >>> verilog/tpcd_decoder.sv
// Serial command decoder and control registers of the tone processor.
`timescale 1ns/10ps
// Notes on behaviour
// - First byte of each frame is the command; later bytes follow it.
// - After the command come host data bytes or a device reply.
// - Command 30h plus one byte loads the control register.
// - Command 31h returns one byte of status.
// - Command 32h returns two bytes of measured tone frequency.
// - Command 33h plus one byte loads the tone-loss timeout.
// - Command 34h plus two bytes loads the first tone setting.
// - Command 35h plus two bytes loads the second tone setting.
// - Command 36h plus one byte loads the interval timer period.
// - Control bit 7 closes the audio switch.
// - Bit 6 enables timer interrupt, bit 5 decoder interrupts.
// - Status bits 0 to 2 set on events whatever the enables.
// - Control bit 4 closes the summing switch.
// - Control bits 3:2 select the band; host never writes 11.
// - Reset command clears the three event flags; status read clears only those it reported.
// - Bit 0 sets on measurement done and may interrupt.
// - New timer period clears that timer's expired flag.
module tpcd_decoder (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ser_clock,
  input  wire logic        ser_cs_b,
  input  wire logic        ser_data_in,
  output logic             ser_reply,
  output logic             ser_reply_oe,
  input  wire logic        meas_done,
  input  wire logic [15:0] rx_freq,
  input  wire logic        loss_expired,
  input  wire logic        timer_expired,
  input  wire logic        logic_in,
  output logic             audio_switch,
  output logic             summing_switch,
  output logic [1:0]       band_sel,
  output logic [7:0]       tone_loss_period,
  output logic             tone_loss_load,
  output logic [7:0]       interval_period,
  output logic             interval_load,
  output logic [15:0]      first_tone,
  output logic             first_tone_load,
  output logic [15:0]      second_tone,
  output logic             second_tone_load,
  output logic             irq
);

  // ****************************************
  // State types
  // ****************************************
  typedef struct packed {
    logic [2:0]  bitn;
    logic        first;
    logic [6:0]  shift;
    logic [15:0] rsh;
    logic [4:0]  rleft;
    logic        rout;
    logic        roe;
  } tpcd_frame_t;

  typedef struct packed {
    logic [7:0] hold;
    logic       tog;
  } tpcd_xfer_t;

  typedef struct packed {
    logic [2:0]          tsync;
    logic [1:0]          csync;
    logic [1:0]          lsync;
    tpcd_pkg::tpcd_phase_t phase;
    logic [7:0]          cmd;
    logic [7:0]          hi;
    logic [7:0]          ctrl;
    logic [2:0]          flags;
    logic [23:0]         rhold;
    logic [7:0]          loss;
    logic [7:0]          intv;
    logic [15:0]         t1;
    logic [15:0]         t2;
    logic                loss_ld;
    logic                intv_ld;
    logic                t1_ld;
    logic                t2_ld;
    logic                irq;
  } tpcd_core_t;

  tpcd_frame_t f;
  tpcd_frame_t next_f;
  tpcd_xfer_t  x;
  tpcd_xfer_t  next_x;
  tpcd_core_t  c;
  tpcd_core_t  next_c;
  logic        link_arst_b;
  logic [7:0]  rx_byte;
  logic        new_byte;
  logic        idle;
  logic [7:0]  b;
  logic [2:0]  clr;
  logic [2:0]  ev;

  // ****************************************
  // Link side, on the serial clock
  // ****************************************
  // The serial clock stops between frames, so the frame state is
  // cleared by the select going high rather than by a clock edge.
  assign link_arst_b = rst_b & ~ser_cs_b;
  assign rx_byte     = {f.shift, ser_data_in};

  always_comb begin
    next_f = f;
    next_x = x;
    next_f.bitn  = f.bitn + 3'h1;
    next_f.shift = rx_byte[6:0];
    if (f.rleft != 5'h00) begin
      next_f.rout  = f.rsh[15];
      next_f.rsh   = {f.rsh[14:0], 1'b0};
      next_f.rleft = f.rleft - 5'h01;
    end else begin
      next_f.roe  = 1'b0;
      next_f.rout = 1'b0;
    end
    if (f.bitn == tpcd_pkg::LAST_BIT) begin
      next_x.hold = rx_byte;
      next_x.tog  = ~x.tog;
      next_f.first = 1'b0;
      if (f.first) begin
        if (rx_byte == tpcd_pkg::CMD_STAT) begin
          next_f.rout  = c.rhold[23];
          next_f.rsh   = {c.rhold[22:16], 9'h000};
          next_f.rleft = tpcd_pkg::STAT_BITS;
          next_f.roe   = 1'b1;
        end else if (rx_byte == tpcd_pkg::CMD_FREQ) begin
          next_f.rout  = c.rhold[15];
          next_f.rsh   = {c.rhold[14:0], 1'b0};
          next_f.rleft = tpcd_pkg::FREQ_BITS;
          next_f.roe   = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ser_clock or negedge link_arst_b) begin
    if (!link_arst_b) begin
      f <= '{bitn: 3'h0, first: 1'b1, shift: 7'h00, rsh: 16'h0000,
             rleft: 5'h00, rout: 1'b0, roe: 1'b0};
    end else begin
      f <= next_f;
    end
  end

  // The byte handed across keeps its value for the eight serial clocks
  // of the next byte, which is far longer than the toggle sync delay.
  always_ff @(posedge ser_clock or negedge rst_b) begin
    if (!rst_b) begin
      x <= '{hold: 8'h00, tog: 1'b0};
    end else begin
      x <= next_x;
    end
  end

  assign ser_reply    = f.rout;
  assign ser_reply_oe = f.roe;

  // ****************************************
  // Core side, on the system clock
  // ****************************************
  assign new_byte = c.tsync[2] ^ c.tsync[1];
  assign idle     = c.csync[1];
  assign b        = x.hold;
  assign ev       = {timer_expired, loss_expired, meas_done};

  always_comb begin
    next_c = c;
    clr    = 3'h0;
    next_c.tsync   = {c.tsync[1:0], x.tog};
    next_c.csync   = {c.csync[0], ser_cs_b};
    next_c.lsync   = {c.lsync[0], logic_in};
    next_c.loss_ld = 1'b0;
    next_c.intv_ld = 1'b0;
    next_c.t1_ld   = 1'b0;
    next_c.t2_ld   = 1'b0;
    // The reply snapshot is frozen for the whole frame; a read clears
    // only the flags that were actually reported.
    if (idle) begin
      next_c.rhold = {4'h0, c.lsync[1], c.flags, rx_freq};
    end
    if (new_byte) begin
      case (c.phase)
        tpcd_pkg::TPCD_CMD: begin
          next_c.cmd   = b;
          next_c.phase = tpcd_pkg::TPCD_BYTE1;
          if (b == tpcd_pkg::CMD_RESET) begin
            next_c.ctrl    = tpcd_pkg::CTRL_RST;
            next_c.intv    = tpcd_pkg::PERIOD_RST;
            next_c.intv_ld = 1'b1;
            clr            = 3'h7;
          end else if (b == tpcd_pkg::CMD_STAT) begin
            clr = c.rhold[18:16];
          end
        end
        tpcd_pkg::TPCD_BYTE1: begin
          next_c.hi    = b;
          next_c.phase = tpcd_pkg::TPCD_BYTE2;
          case (c.cmd)
            tpcd_pkg::CMD_CTRL: begin
              next_c.ctrl = {b[7:2], 2'h0};
            end
            tpcd_pkg::CMD_LOSS: begin
              next_c.loss    = b;
              next_c.loss_ld = 1'b1;
              clr[tpcd_pkg::ST_LOSS] = 1'b1;
            end
            tpcd_pkg::CMD_TIMER: begin
              next_c.intv    = b;
              next_c.intv_ld = 1'b1;
              clr[tpcd_pkg::ST_TIMER] = 1'b1;
            end
            default: begin
            end
          endcase
        end
        tpcd_pkg::TPCD_BYTE2: begin
          next_c.phase = tpcd_pkg::TPCD_SKIP;
          case (c.cmd)
            tpcd_pkg::CMD_TONE1: begin
              next_c.t1    = {c.hi, b};
              next_c.t1_ld = 1'b1;
            end
            tpcd_pkg::CMD_TONE2: begin
              next_c.t2    = {c.hi, b};
              next_c.t2_ld = 1'b1;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end else if (idle) begin
      next_c.phase = tpcd_pkg::TPCD_CMD;
    end
    // An event in the clearing cycle still sets its flag.
    next_c.flags = (c.flags & ~clr) | ev;
    next_c.irq =
      (next_c.ctrl[tpcd_pkg::CTL_TX_IE] &
       next_c.flags[tpcd_pkg::ST_TIMER]) |
      (next_c.ctrl[tpcd_pkg::CTL_DEC_IE] &
       (next_c.flags[tpcd_pkg::ST_MEAS] |
        next_c.flags[tpcd_pkg::ST_LOSS]));
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      c <= '{tsync: 3'h0, csync: 2'h3, lsync: 2'h0,
             phase: tpcd_pkg::TPCD_CMD, cmd: 8'h00, hi: 8'h00,
             ctrl: tpcd_pkg::CTRL_RST, flags: 3'h0, rhold: 24'h000000,
             loss: tpcd_pkg::PERIOD_RST, intv: tpcd_pkg::PERIOD_RST,
             t1: tpcd_pkg::TONE_RST, t2: tpcd_pkg::TONE_RST,
             loss_ld: 1'b0, intv_ld: 1'b0, t1_ld: 1'b0, t2_ld: 1'b0,
             irq: 1'b0};
    end else begin
      c <= next_c;
    end
  end

  assign audio_switch     = c.ctrl[tpcd_pkg::CTL_AUDIO];
  assign summing_switch   = c.ctrl[tpcd_pkg::CTL_SUM];
  assign band_sel         =
    c.ctrl[tpcd_pkg::CTL_BAND_HI:tpcd_pkg::CTL_BAND_LO];
  assign tone_loss_period = c.loss;
  assign tone_loss_load   = c.loss_ld;
  assign interval_period  = c.intv;
  assign interval_load    = c.intv_ld;
  assign first_tone       = c.t1;
  assign first_tone_load  = c.t1_ld;
  assign second_tone      = c.t2;
  assign second_tone_load = c.t2_ld;
  assign irq              = c.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_meas_flag_set: assert property (meas_done |=> c.flags[0])
    else $error("measurement flag not set");
  a_loss_flag_set: assert property (loss_expired |=> c.flags[1])
    else $error("tone-loss flag not set");
  a_timer_flag_set: assert property (timer_expired |=> c.flags[2])
    else $error("timer flag not set");
  a_irq_from_flags: assert property (
    ##1 irq == ((c.ctrl[6] & c.flags[2]) |
                (c.ctrl[5] & (c.flags[0] | c.flags[1]))))
    else $error("interrupt does not match enabled flags");
  a_ctrl_write: assert property (
    new_byte && c.phase == tpcd_pkg::TPCD_BYTE1 &&
    c.cmd == tpcd_pkg::CMD_CTRL
    |=> audio_switch == $past(b[7]) && summing_switch == $past(b[4]))
    else $error("control write not applied");
  a_timer_period_load: assert property (
    new_byte && c.phase == tpcd_pkg::TPCD_BYTE1 &&
    c.cmd == tpcd_pkg::CMD_TIMER && !timer_expired
    |=> interval_load && interval_period == $past(b) && !c.flags[2])
    else $error("timer period write wrong");
  a_loss_period_load: assert property (
    new_byte && c.phase == tpcd_pkg::TPCD_BYTE1 &&
    c.cmd == tpcd_pkg::CMD_LOSS && !loss_expired
    |=> tone_loss_load && tone_loss_period == $past(b) && !c.flags[1])
    else $error("tone-loss write wrong");
  a_reset_cmd_clear: assert property (
    new_byte && c.phase == tpcd_pkg::TPCD_CMD &&
    b == tpcd_pkg::CMD_RESET && !timer_expired
    |=> interval_period == 8'h00 && !c.flags[2] && !irq)
    else $error("reset command incomplete");
  a_stat_read_clear: assert property (
    new_byte && c.phase == tpcd_pkg::TPCD_CMD &&
    b == tpcd_pkg::CMD_STAT && c.rhold[16] && !meas_done
    |=> !c.flags[0])
    else $error("status read did not clear flag");
  a_tone1_pairing: assert property (
    new_byte && c.phase == tpcd_pkg::TPCD_BYTE2 &&
    c.cmd == tpcd_pkg::CMD_TONE1
    |=> first_tone_load && first_tone == {$past(c.hi), $past(b)})
    else $error("first tone word wrong");
  a_stat_reply: assert property (
    @(posedge ser_clock) disable iff (!link_arst_b)
    f.first && f.bitn == 3'h7 && rx_byte == tpcd_pkg::CMD_STAT
    |=> ser_reply_oe && ser_reply == $past(c.rhold[23]))
    else $error("status reply not started");
  a_freq_reply_len: assert property (
    @(posedge ser_clock) disable iff (!link_arst_b)
    f.first && f.bitn == 3'h7 && rx_byte == tpcd_pkg::CMD_FREQ
    |=> ser_reply_oe [*8])
    else $error("frequency reply cut short");

  c_stat_read: cover property (
    new_byte && c.phase == tpcd_pkg::TPCD_CMD && b == tpcd_pkg::CMD_STAT);
  c_tone2_write: cover property (second_tone_load);
  c_irq_rise: cover property (!irq ##1 irq);
  c_set_on_clear: cover property (|(clr & ev));

endmodule

// >>> dv/tpcd_host_model.sv
// Host model that drives the serial command link of the decoder.
`timescale 1ns/10ps
module tpcd_host_model (
  output logic      ser_clock,
  output logic      ser_cs_b,
  output logic      ser_data_in,
  input  wire logic ser_reply,
  input  wire logic ser_reply_oe
);

  // The link clock stands still low between frames.
  initial begin
    ser_clock   = 1'b0;
    ser_cs_b    = 1'b1;
    ser_data_in = 1'b0;
  end

  task automatic send_bit(input logic b);
    ser_data_in = b;
    #62.5 ser_clock = 1'b1;
    #62.5 ser_clock = 1'b0;
  endtask

  // Data bytes are taken from the top of wdata, MSB first.
  task automatic frame(input  logic [7:0]  cmd,
                       input  int          n_wr,
                       input  logic [15:0] wdata,
                       input  int          n_rd,
                       output logic [15:0] rdata,
                       output logic        oe_ok);
    rdata = 16'h0000;
    oe_ok = 1'b1;
    ser_cs_b = 1'b0;
    #30;
    for (int i = 7; i >= 0; i--) send_bit(cmd[i]);
    for (int i = 15; i > 15 - n_wr; i--) send_bit(wdata[i]);
    for (int i = 0; i < n_rd; i++) begin
      // The data line is not looked at now, so it keeps changing.
      ser_data_in = ~ser_data_in;
      #61.5;
      rdata = {rdata[14:0], ser_reply};
      oe_ok = oe_ok & ser_reply_oe;
      #1 ser_clock = 1'b1;
      #62.5 ser_clock = 1'b0;
    end
    #30 ser_cs_b = 1'b1;
    ser_data_in = ~ser_data_in;
    #50;
  endtask

endmodule

// >>> dv/testbench.sv
// Self-checking bench for the tone processor command decoder.
`timescale 1ns/10ps
module testbench;

  logic        clock;
  logic        rst_b;
  logic        ser_clock;
  logic        ser_cs_b;
  logic        ser_data_in;
  logic        ser_reply;
  logic        ser_reply_oe;
  logic        meas_done;
  logic [15:0] rx_freq;
  logic        loss_expired;
  logic        timer_expired;
  logic        logic_in;
  logic        audio_switch;
  logic        summing_switch;
  logic [1:0]  band_sel;
  logic [7:0]  tone_loss_period;
  logic        tone_loss_load;
  logic [7:0]  interval_period;
  logic        interval_load;
  logic [15:0] first_tone;
  logic        first_tone_load;
  logic [15:0] second_tone;
  logic        second_tone_load;
  logic        irq;
  logic [15:0] n_loads;
  logic [15:0] n0;
  logic [15:0] r;
  int          n_errors;
  int          n_checks;
  int          cycles;

  logic        unused_oe;

  tpcd_decoder tpcd_decoder_inst (
    .clock            (clock),
    .rst_b            (rst_b),
    .ser_clock        (ser_clock),
    .ser_cs_b         (ser_cs_b),
    .ser_data_in      (ser_data_in),
    .ser_reply        (ser_reply),
    .ser_reply_oe     (ser_reply_oe),
    .meas_done        (meas_done),
    .rx_freq          (rx_freq),
    .loss_expired     (loss_expired),
    .timer_expired    (timer_expired),
    .logic_in         (logic_in),
    .audio_switch     (audio_switch),
    .summing_switch   (summing_switch),
    .band_sel         (band_sel),
    .tone_loss_period (tone_loss_period),
    .tone_loss_load   (tone_loss_load),
    .interval_period  (interval_period),
    .interval_load    (interval_load),
    .first_tone       (first_tone),
    .first_tone_load  (first_tone_load),
    .second_tone      (second_tone),
    .second_tone_load (second_tone_load),
    .irq              (irq)
  );
  tpcd_host_model tpcd_host_model_inst (.ser_clock(ser_clock),
    .ser_cs_b(ser_cs_b), .ser_data_in(ser_data_in),
    .ser_reply(ser_reply), .ser_reply_oe(ser_reply_oe));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************************************
  // Load pulse counter and hang guard
  // ****************************************
  always @(posedge clock) begin
    if ((tone_loss_load | interval_load | first_tone_load
         | second_tone_load) === 1'b1) begin
      n_loads <= n_loads + 16'h0001;
    end
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge clock);
    #1;
  endtask

  task automatic wr1(input logic [7:0] cmd, input logic [7:0] v);
    logic [15:0] rd_unused;
    logic        oe_unused;
    tpcd_host_model_inst.frame(cmd, 8, {v, 8'h00}, 0, rd_unused, oe_unused);
    settle();
  endtask

  task automatic wr2(input logic [7:0] cmd, input logic [15:0] v);
    logic [15:0] rd_unused;
    logic        oe_unused;
    tpcd_host_model_inst.frame(cmd, 16, v, 0, rd_unused, oe_unused);
    settle();
  endtask

  task automatic rd(input logic [7:0] cmd, input int n,
                    output logic [15:0] v);
    logic oe;
    tpcd_host_model_inst.frame(cmd, 0, 16'h0000, n, v, oe);
    chk("ser_reply_oe", 16'h0001, {15'h0000, oe});
    settle();
  endtask

  // Event pulses are ordered {timer, loss, measurement}.
  task automatic pulse(input logic [2:0] ev);
    @(posedge clock);
    #1 {timer_expired, loss_expired, meas_done} = ev;
    @(posedge clock);
    #1 {timer_expired, loss_expired, meas_done} = 3'h0;
    settle();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b, meas_done, loss_expired, timer_expired} = 4'h0;
    rx_freq = 16'hc3a5;
    logic_in = 1'b1;
    n_loads = 16'h0000;
    {n_errors, n_checks, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    settle();
    chk("irq", 16'h0000, {15'h0000, irq});
    chk("interval_period", 16'h0000, {8'h00, interval_period});
    // Host never writes band 11 nor ones to bits 1:0.
    for (int b = 0; b < 3; b++) begin
      wr1(tpcd_pkg::CMD_CTRL, {4'h9, b[1:0], 2'h0});
      chk("audio_switch", 16'h0001, {15'h0000, audio_switch});
      chk("summing_switch", 16'h0001, {15'h0000, summing_switch});
      chk("band_sel", {14'h0000, b[1:0]}, {14'h0000, band_sel});
    end
    wr1(tpcd_pkg::CMD_CTRL, 8'h00);
    chk("audio_switch", 16'h0000, {15'h0000, audio_switch});
    chk("summing_switch", 16'h0000, {15'h0000, summing_switch});
    n0 = n_loads;
    wr1(tpcd_pkg::CMD_LOSS, 8'ha5);
    chk("tone_loss_period", 16'h00a5, {8'h00, tone_loss_period});
    wr2(tpcd_pkg::CMD_TONE1, 16'h1234);
    chk("first_tone", 16'h1234, first_tone);
    wr2(tpcd_pkg::CMD_TONE2, 16'hbeef);
    chk("second_tone", 16'hbeef, second_tone);
    wr1(tpcd_pkg::CMD_TIMER, 8'h05);
    chk("interval_period", 16'h0005, {8'h00, interval_period});
    wr1(8'h55, 8'hff);
    chk("loads", n0 + 16'h0004, n_loads);
    chk("audio_switch", 16'h0000, {15'h0000, audio_switch});
    pulse(3'h7);
    chk("irq", 16'h0000, {15'h0000, irq});
    rd(tpcd_pkg::CMD_STAT, 8, r);
    chk("status", 16'h000f, r);
    rd(tpcd_pkg::CMD_STAT, 8, r);
    chk("status", 16'h0008, r);
    rd(tpcd_pkg::CMD_FREQ, 16, r);
    chk("rx_freq", 16'hc3a5, r);
    wr1(tpcd_pkg::CMD_CTRL, 8'h40);
    pulse(3'h4);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr1(tpcd_pkg::CMD_TIMER, 8'h21);
    chk("irq", 16'h0000, {15'h0000, irq});
    pulse(3'h2);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr1(tpcd_pkg::CMD_CTRL, 8'h20);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr1(tpcd_pkg::CMD_LOSS, 8'h10);
    chk("irq", 16'h0000, {15'h0000, irq});
    pulse(3'h1);
    chk("irq", 16'h0001, {15'h0000, irq});
    rd(tpcd_pkg::CMD_STAT, 8, r);
    chk("status", 16'h0009, r);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr1(tpcd_pkg::CMD_CTRL, 8'h94);
    pulse(3'h7);
    n0 = n_loads;
    tpcd_host_model_inst.frame(tpcd_pkg::CMD_RESET, 0, 16'h0000, 0,
                               r, unused_oe);
    settle();
    chk("interval_period", 16'h0000, {8'h00, interval_period});
    chk("loads", n0 + 16'h0001, n_loads);
    chk("audio_switch", 16'h0000, {15'h0000, audio_switch});
    chk("tone_loss_period", 16'h0010, {8'h00, tone_loss_period});
    rd(tpcd_pkg::CMD_STAT, 8, r);
    chk("status", 16'h0008, r);
    end_of_test();
  end

endmodule
